// [rtl/sacs_top.v]
// control sequencer of the self-calibrating sign-plus-12-bit converter
//
// Summary of operation
// - write pulse with chip select low and null high starts a plain conversion
// - null request low at start adds offset-null phase; sampled once at start
// - result bus drives all 13 bits only while select and read are low
// - calibrate input going low starts a calibration cycle
// - select and calibrate low with read high drives bits 2,3,5,6 in test mode
// - select and write low resets sequencing and abandons any conversion
// - a running calibration ignores starts and resets until it ends
// - after reset a calibration of 1396 cycles runs on its own
// - calibration stores offset and bit corrections; later conversions apply the bit corrections, and the offset only without null phase
// - result codes span 4095 positive and 4096 negative values
// - input sampled for 7 clock periods after write rises, then held
// - offset-null phase of 26 periods precedes sampling
// - busy low from end of sampling through conversion, and through calibration
// - ready falls when result latched; rises on read, start or calibration
// - result is two's complement, bit 12 the sign, low for positive
`timescale 1ns/1ps
`default_nettype none
`include "sacs_regs.vh"
module sacs_top (
  // clock, reset, enable
  input wire CLK_SYS,
  input wire RESET_N,
  input wire CLK_EN,
  // host control strobes, active low
  input wire CS_N,
  input wire WR_N,
  input wire RD_N,
  input wire CAL_N,
  input wire OFFSET_NULL_REQUEST_N,
  // analog front end
  input wire COMP_IN,
  output reg TRACK,
  output reg [12:0] DAC_CODE,
  output reg [7:0] DAC_TRIM,
  // host status and result bus
  output reg BUSY_N,
  output reg RESULT_READY_N,
  output reg [12:0] RESULT_BUS_O,
  output wire [12:0] RESULT_BUS_OE
);
  reg [4:0] in_s1_r;
  reg [4:0] in_s2_r;
  reg start_lo_d_r;
  reg cal_lo_d_r;
  reg [2:0] state_r;
  reg [10:0] cnt_r;
  reg [6:0] ones_r;
  reg use_az_r;
  reg [7:0] az_off_r;
  reg [7:0] off_r;
  reg [3:0] bit_r;
  reg [1:0] ph_r;
  reg [12:0] code_r;
  reg [12:0] result_r;
  wire [7:0] mem_rd;
  reg [3:0] mem_addr;
  reg mem_we;
  reg [7:0] mem_wd;
  wire cs_lo;
  wire wr_lo;
  wire rd_lo;
  wire cal_lo;
  wire az_lo;
  wire start_lo;
  wire start_go;
  wire cal_go;
  wire rd_go;
  wire test_mode;
  wire [3:0] slot;
  wire [12:0] trial;
  wire [12:0] test_word;

  // synchronised strobe levels, taken from the second stage only
  assign cs_lo = ~in_s2_r[0];
  assign wr_lo = ~in_s2_r[1];
  assign rd_lo = ~in_s2_r[2];
  assign cal_lo = ~in_s2_r[3];
  assign az_lo = ~in_s2_r[4];

  // decoded host requests
  assign start_lo = cs_lo & wr_lo;
  assign start_go = start_lo_d_r & cs_lo & ~wr_lo;
  assign cal_go = cal_lo & ~cal_lo_d_r;
  assign rd_go = cs_lo & rd_lo;
  assign test_mode = cs_lo & cal_lo & ~rd_lo;

  // calibration slot and trial code of the current bit
  assign slot = cnt_r[9:6];
  assign trial = (bit_r == `SACS_SIGN_BIT) ? 13'h0000 :
                 (code_r | (13'h0001 << bit_r));
  assign test_word = {6'h00, state_r[2], state_r[1], 1'b0,
                      state_r[0], TRACK, 2'h0};

  // bus enables: full word on read, four bits in test mode
  assign RESULT_BUS_OE = rd_go ? 13'h1fff :
                         (test_mode ? `SACS_TEST_MASK : 13'h0000);

  // correction store access
  always @* begin
    mem_addr = 4'h0;
    mem_we = 1'b0;
    mem_wd = 8'h00;
    if (state_r == `SACS_ST_CAL) begin
      mem_addr = slot;
      mem_we = (cnt_r < `SACS_CAL_MEAS) && (cnt_r[5:0] == 6'h3f);
      mem_wd = {1'b0, ones_r} + {7'h00, COMP_IN} - `SACS_SLOT_MID;
    end else if (state_r == `SACS_ST_SAR) begin
      mem_addr = (bit_r == `SACS_SIGN_BIT) ? 4'h0 : bit_r + 4'h1;
    end
  end

  sacs_cal_mem u_mem (
    .CLK_SYS(CLK_SYS),
    .CLK_EN(CLK_EN),
    .ADDR(mem_addr),
    .WE(mem_we),
    .WDATA(mem_wd),
    .RDATA(mem_rd)
  );

  // sequencer
  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      in_s1_r <= 5'h1f;
      in_s2_r <= 5'h1f;
      start_lo_d_r <= 1'b0;
      cal_lo_d_r <= 1'b0;
      state_r <= `SACS_ST_CAL;
      cnt_r <= 11'h000;
      ones_r <= 7'h00;
      use_az_r <= 1'b0;
      az_off_r <= 8'h00;
      off_r <= 8'h00;
      bit_r <= `SACS_SIGN_BIT;
      ph_r <= 2'h0;
      code_r <= 13'h0000;
      result_r <= 13'h0000;
      TRACK <= 1'b0;
      DAC_CODE <= 13'h0000;
      DAC_TRIM <= 8'h00;
      BUSY_N <= 1'b0;
      RESULT_READY_N <= 1'b1;
      RESULT_BUS_O <= 13'h0000;
    end else if (CLK_EN) begin
      in_s1_r <= {OFFSET_NULL_REQUEST_N, CAL_N, RD_N, WR_N, CS_N};
      in_s2_r <= in_s1_r;
      start_lo_d_r <= start_lo;
      cal_lo_d_r <= cal_lo;
      RESULT_BUS_O <= test_mode ? test_word : result_r;
      if (rd_go) begin
        RESULT_READY_N <= 1'b1;
      end
      if (state_r == `SACS_ST_CAL) begin
        // uninterruptible calibration, measures each slot
        cnt_r <= cnt_r + 11'h001;
        TRACK <= 1'b0;
        DAC_TRIM <= 8'h00;
        DAC_CODE <= (slot == 4'h0 || cnt_r >= `SACS_CAL_MEAS) ? 13'h0000 :
                    (13'h0001 << (slot - 4'h1));
        ones_r <= (cnt_r[5:0] == 6'h3f) ? 7'h00 : ones_r + {6'h00, COMP_IN};
        if (cnt_r == `SACS_CAL_CYC - 11'h001) begin
          state_r <= `SACS_ST_IDLE;
          BUSY_N <= 1'b1;
        end
      end else if (cal_go) begin
        state_r <= `SACS_ST_CAL;
        cnt_r <= 11'h000;
        ones_r <= 7'h00;
        BUSY_N <= 1'b0;
        RESULT_READY_N <= 1'b1;
      end else if (start_lo) begin
        // held start: state, track, busy and ready back to idle; DAC code and trim hold
        state_r <= `SACS_ST_IDLE;
        TRACK <= 1'b0;
        BUSY_N <= 1'b1;
        RESULT_READY_N <= 1'b1;
      end else if (start_go) begin
        use_az_r <= az_lo;
        state_r <= az_lo ? `SACS_ST_AZ : `SACS_ST_SAMPLE;
        TRACK <= ~az_lo;
        cnt_r <= 11'h000;
        ones_r <= 7'h00;
        DAC_CODE <= 13'h0000;
        DAC_TRIM <= 8'h00;
      end else begin
        case (state_r)
          `SACS_ST_AZ: begin
            // comparator offset measured against ground
            cnt_r <= cnt_r + 11'h001;
            ones_r <= ones_r + {6'h00, COMP_IN};
            if (cnt_r == `SACS_AZ_CYC - 11'h001) begin
              az_off_r <= {1'b0, ones_r} + {7'h00, COMP_IN} -
                          `SACS_AZ_MID;
              state_r <= `SACS_ST_SAMPLE;
              TRACK <= 1'b1;
              cnt_r <= 11'h000;
            end
          end
          `SACS_ST_SAMPLE: begin
            // acquisition window, then internal hold
            cnt_r <= cnt_r + 11'h001;
            if (cnt_r == `SACS_ACQ_CYC - 11'h001) begin
              TRACK <= 1'b0;
              BUSY_N <= 1'b0;
              state_r <= `SACS_ST_SAR;
              bit_r <= `SACS_SIGN_BIT;
              ph_r <= 2'h0;
              code_r <= 13'h0000;
            end
          end
          `SACS_ST_SAR: begin
            // three phases per bit: address, trim, decide
            ph_r <= ph_r + 2'h1;
            if (ph_r == 2'h0) begin
              DAC_CODE <= trial;
            end else if (ph_r == 2'h1) begin
              if (bit_r == `SACS_SIGN_BIT) begin
                off_r <= use_az_r ? az_off_r : mem_rd;
                DAC_TRIM <= use_az_r ? az_off_r : mem_rd;
              end else begin
                DAC_TRIM <= off_r + mem_rd;
              end
            end else begin
              ph_r <= 2'h0;
              if (bit_r == `SACS_SIGN_BIT) begin
                code_r <= {~COMP_IN, 12'h000};
                bit_r <= 4'hb;
              end else begin
                code_r[bit_r] <= COMP_IN;
                if (bit_r == 4'h0) begin
                  result_r <= {code_r[12:1], COMP_IN};
                  state_r <= `SACS_ST_DONE;
                end else begin
                  bit_r <= bit_r - 4'h1;
                end
              end
            end
          end
          `SACS_ST_DONE: begin
            BUSY_N <= 1'b1;
            RESULT_READY_N <= 1'b0;
            state_r <= `SACS_ST_IDLE;
          end
          `SACS_ST_IDLE: begin
            TRACK <= 1'b0;
          end
          default: begin
            state_r <= `SACS_ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/sacs_regs.vh]
// timing counts, state codes and field constants of the converter sequencer
`ifndef SACS_REGS_VH
`define SACS_REGS_VH
`define SACS_RES_W 13
`define SACS_TRIM_W 8
`define SACS_SIGN_BIT 4'hc
`define SACS_ACQ_CYC 11'h007
`define SACS_AZ_CYC 11'h01a
`define SACS_AZ_MID 8'h0d
`define SACS_CAL_CYC 11'h574
`define SACS_CAL_MEAS 11'h340
`define SACS_SLOT_MID 8'h20
`define SACS_TEST_MASK 13'h006c
`define SACS_ST_IDLE 3'h0
`define SACS_ST_AZ 3'h1
`define SACS_ST_SAMPLE 3'h2
`define SACS_ST_SAR 3'h3
`define SACS_ST_DONE 3'h4
`define SACS_ST_CAL 3'h5
`endif

// [rtl/sacs_cal_mem.v]
// correction factor store with registered read data
`timescale 1ns/1ps
`default_nettype none
module sacs_cal_mem (
  // clocking
  input wire CLK_SYS,
  input wire CLK_EN,
  // access port
  input wire [3:0] ADDR,
  input wire WE,
  input wire [7:0] WDATA,
  output reg [7:0] RDATA
);
  reg [7:0] mem_r [0:15];

  // one optional write and one registered read per enabled cycle
  always @(posedge CLK_SYS) begin
    if (CLK_EN) begin
      if (WE) begin
        mem_r[ADDR] <= WDATA;
      end
      RDATA <= mem_r[ADDR];
    end
  end
endmodule
`default_nettype wire

// [bench/sacs_assertions.sv]
// port checks of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sacs_chk (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  // host strobes
  input wire logic CS_N,
  input wire logic WR_N,
  input wire logic RD_N,
  input wire logic CAL_N,
  // status and bus
  input wire logic TRACK,
  input wire logic BUSY_N,
  input wire logic RESULT_READY_N,
  input wire logic [12:0] RESULT_BUS_OE
);
  logic [10:0] low_cnt_r;
  wire hold_w = !CS_N && !WR_N;
  // cycles busy has been low
  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) low_cnt_r <= 11'h000;
    else low_cnt_r <= BUSY_N ? 11'h000 : low_cnt_r + 11'h001;
  end
  default clocking @(posedge CLK_SYS); endclocking
  sequence sample_s;
    TRACK [*7] ##1 !TRACK;
  endsequence
  sequence convert_s;
    !BUSY_N [*8] ##[20:40] ($rose(BUSY_N) && !RESULT_READY_N);
  endsequence
  track_len_a: assert property (disable iff (!RESET_N || hold_w)
    $rose(TRACK) |-> sample_s) else $error("sampling window short");
  conv_len_a: assert property (disable iff (!RESET_N || hold_w)
    $fell(TRACK) |-> convert_s) else $error("conversion timing wrong");
  cal_len_a: assert property (disable iff (!RESET_N || hold_w)
    $rose(BUSY_N) && RESULT_READY_N |-> low_cnt_r inside {[11'h574:11'h575]})
    else $error("calibration length wrong");
  cal_start_a: assert property (disable iff (!RESET_N)
    $past(CAL_N, 3) && !$past(CAL_N, 2) && BUSY_N |-> ##[1:2] !BUSY_N)
    else $error("calibration not started");
  read_oe_a: assert property (disable iff (!RESET_N)
    !$past(CS_N, 2) && !$past(RD_N, 2) |-> RESULT_BUS_OE == 13'h1fff)
    else $error("read enable wrong");
  test_oe_a: assert property (disable iff (!RESET_N)
    !$past(CS_N, 2) && $past(RD_N, 2) && !$past(CAL_N, 2)
    |-> RESULT_BUS_OE == 13'h006c) else $error("test enable wrong");
  idle_oe_a: assert property (disable iff (!RESET_N)
    $past(CS_N, 2) |-> RESULT_BUS_OE == 13'h0000) else $error("bus driven");
  read_clr_a: assert property (disable iff (!RESET_N)
    !$past(CS_N, 2) && !$past(RD_N, 2) && !RESULT_READY_N |=> RESULT_READY_N)
    else $error("ready not cleared by read");
endmodule
`default_nettype wire

// [bench/sacs_host.sv]
// host model driving the sequencer strobes
`timescale 1ns/1ps
`default_nettype none
module sacs_host (
  // clock
  input wire logic clk,
  // strobes, order cs wr rd cal null
  output var logic cs_n,
  output var logic wr_n,
  output var logic rd_n,
  output var logic cal_n,
  output var logic az_n
);
  initial {cs_n, wr_n, rd_n, cal_n, az_n} = 5'h1f;
  // set one pattern after an edge and hold it n cycles
  task automatic drive(input logic [4:0] v, input int n);
    @(posedge clk);
    {cs_n, wr_n, rd_n, cal_n, az_n} <= v;
    repeat (n - 1) @(posedge clk);
  endtask
  // start: write rises while select still low, null request held steady
  task automatic start(input logic az);
    drive({4'h3, az}, 3);
    drive({4'h7, az}, 1);
    drive({4'hf, az}, 1);
  endtask
  // read with select and read low, write and calibrate high
  task automatic rd(input int n);
    drive({4'h5, az_n}, n);
    drive({4'hf, az_n}, 1);
  endtask
  // calibrate with select, read and write high
  task automatic cal;
    drive({4'he, az_n}, 3);
    drive({4'hf, az_n}, 1);
  endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  failures++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic CLK_SYS = 1'b0, RESET_N = 1'b0, comp_in = 1'b0;
  wire cs_n, wr_n, rd_n, cal_n, az_n, track, busy_n, rdy_n;
  wire [12:0] dac, res, oe;
  wire [7:0] trim;
  int failures = 0, comparisons = 0, cycles = 0, n0, n1;
  initial forever #20 CLK_SYS = ~CLK_SYS;
  sacs_host i_host (.clk(CLK_SYS), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .cal_n(cal_n), .az_n(az_n));
  sacs_top i_dut (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .CLK_EN(1'b1),
    .CS_N(cs_n), .WR_N(wr_n), .RD_N(rd_n), .CAL_N(cal_n),
    .OFFSET_NULL_REQUEST_N(az_n), .COMP_IN(comp_in), .TRACK(track),
    .DAC_CODE(dac), .DAC_TRIM(trim), .BUSY_N(busy_n),
    .RESULT_READY_N(rdy_n), .RESULT_BUS_O(res), .RESULT_BUS_OE(oe));
  // comparator against a fixed positive input
  always @(posedge CLK_SYS) comp_in <= $signed(dac) < $signed(13'h0123);
  // run limit
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end
  task automatic step;
    @(posedge CLK_SYS);
    #1;
  endtask
  // wait for a level of busy, bounded
  task automatic wait_busy(input logic v);
    int k;
    for (k = 0; k < 3000 && busy_n !== v; k++) step();
  endtask
  // power-up calibration ends on its own
  task automatic t_powerup;
    wait_busy(1'b1);
    `CHK("busy", 1'b1, busy_n)
    `CHK("ready", 1'b1, rdy_n)
  endtask
  // calibration ignores a start while running
  task automatic t_cal;
    i_host.cal();
    repeat (3) step();
    `CHK("busy", 1'b0, busy_n)
    `CHK("trim", 8'h00, trim)
    i_host.start(1'b1);
    repeat (40) step();
    `CHK("busy", 1'b0, busy_n)
    `CHK("track", 1'b0, track)
    wait_busy(1'b1);
    `CHK("busy", 1'b1, busy_n)
  endtask
  // one conversion; n is cycles to result, then read
  task automatic t_conv(input logic az, output int n);
    i_host.start(az);
    for (n = 0; n < 300 && rdy_n !== 1'b0; n++) step();
    `CHK("ready", 1'b0, rdy_n)
    `CHK("busy", 1'b1, busy_n)
    `CHK("sign", 1'b0, res[12])
    `CHK("result", 13'h0122, res)
    `CHK("last trial", 13'h0123, dac)
    i_host.rd(4);
    `CHK("oe", 13'h1fff, oe)
    repeat (2) step();
    `CHK("ready", 1'b1, rdy_n)
  endtask
  // null phase adds its cycles
  task automatic t_null;
    t_conv(1'b1, n0);
    t_conv(1'b0, n1);
    `CHK("null", 26, n1 - n0)
  endtask
  // restart mid-conversion abandons it
  task automatic t_abort;
    i_host.start(1'b1);
    repeat (20) step();
    i_host.drive(5'h07, 6);
    `CHK("busy", 1'b1, busy_n)
    `CHK("ready", 1'b1, rdy_n)
    i_host.drive(5'h0f, 1);
    repeat (60) step();
    `CHK("ready", 1'b0, rdy_n)
    i_host.rd(4);
    t_cal();
  endtask
  // test mode drives four bits only
  task automatic t_test;
    i_host.drive(5'h0d, 4);
    `CHK("test oe", 13'h006c, oe)
    i_host.drive(5'h1f, 4);
    `CHK("oe", 13'h0000, oe)
    wait_busy(1'b1);
  endtask
  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge CLK_SYS);
    RESET_N <= 1'b1;
    t_powerup();
    t_cal();
    t_null();
    t_abort();
    t_test();
    results();
  end
endmodule
bind sacs_top sacs_chk i_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
  .CS_N(CS_N), .WR_N(WR_N), .RD_N(RD_N), .CAL_N(CAL_N), .TRACK(TRACK),
  .BUSY_N(BUSY_N), .RESULT_READY_N(RESULT_READY_N),
  .RESULT_BUS_OE(RESULT_BUS_OE));
`default_nettype wire
